//--- logic/cms_cal_sequencer.sv
// Calibration mode sequencer top with its AXI4-Lite register slave.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`default_nettype none
module cms_cal_sequencer
    import cms_pkg::*;
#(
    parameter int OUT_PERIOD_CYC = CMS_OUT_PERIOD_CYC,
    parameter int SCLK_HALF = CMS_SCLK_HALF_CYC
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic sdata_oe,
    input wire logic rfs_n,
    input wire logic tfs_n,
    input wire logic reg_sel,
    input wire logic clk_mode,
    input wire logic [23:0] conv_word,
    output logic [1:0] conv_node,
    output logic period_tick,
    output logic data_ready_n,
    output logic cal_busy
);
    localparam int PW = (OUT_PERIOD_CYC < 2) ? 1 : $clog2(OUT_PERIOD_CYC);
    if (OUT_PERIOD_CYC < 2)
    begin : g_chk
        $error("OUT_PERIOD_CYC must be at least two cycles.");
    end
    typedef enum logic [1:0] {SQ_NORMAL, SQ_CAL, SQ_BG} cms_sq_t;

    function automatic logic [23:0] merge_strb(input logic [23:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [23:0] r;
        r = old;
        for (int i = 0; i < 3; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : merge_strb

    // Bipolar spans only midscale to positive full scale, so the slope doubles.
    function automatic logic [23:0] span(input logic [23:0] full_c,
                                         input logic [23:0] zero_c,
                                         input logic bip);
        logic [23:0] d;
        d = full_c - zero_c;
        return bip ? {d[22:0], 1'b0} : d;
    endfunction : span

    cms_ser_if sif ();
    cms_sq_t st_reg;
    logic [23:0] ctrl_reg;
    logic [23:0] offs_reg;
    logic [23:0] gain_reg;
    logic [23:0] dout_reg;
    logic data_ready_n_n_reg;
    logic first_bad_reg;
    logic bg_pend_reg;
    logic [2:0] code_reg;
    logic [3:0] step_reg;
    logic [PW-1:0] per_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    cms_serial_port #(.SCLK_HALF(SCLK_HALF)) u_port (
        .aclk(aclk),
        .aresetn(aresetn),
        .sclk_in(sclk_in),
        .sclk_out(sclk_out),
        .sclk_oe(sclk_oe),
        .sdata_in(sdata_in),
        .sdata_out(sdata_out),
        .sdata_oe(sdata_oe),
        .rfs_n(rfs_n),
        .tfs_n(tfs_n),
        .reg_sel(reg_sel),
        .clk_mode(clk_mode),
        .sif(sif)
    );

    // Write side: address and data may arrive in either order.
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
    wire wa_ctrl = (awaddr_reg == CMS_OFS_CTRL);
    wire wa_offs = (awaddr_reg == CMS_OFS_OFFS);
    wire wa_gain = (awaddr_reg == CMS_OFS_GAIN);
    wire wa_ro = (awaddr_reg == CMS_OFS_DATA) || (awaddr_reg == CMS_OFS_STAT);
    wire [1:0] wr_resp = (wa_ctrl || wa_offs || wa_gain) ? CMS_RESP_OKAY :
                         (wa_ro ? CMS_RESP_SLVERR : CMS_RESP_DECERR);
    wire axi_ctrl_wr = wr_fire && wa_ctrl;
    wire axi_offs_wr = wr_fire && wa_offs;
    wire axi_gain_wr = wr_fire && wa_gain;
    wire calsel = ctrl_reg[CMS_CALSEL_POS];
    wire ser_offs_wr = sif.wr_cal && !calsel;
    wire ser_gain_wr = sif.wr_cal && calsel;

    always_ff @(posedge aclk)
    begin
        aw_got_reg <= aresetn && !wr_fire && (aw_got_reg || aw_hs);
        w_got_reg <= aresetn && !wr_fire && (w_got_reg || w_hs);
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            awaddr_reg <= 8'h00;
        else if (aw_hs)
            awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
        if (!aresetn)
            {wdata_reg, wstrb_reg} <= 36'h000000000;
        else if (w_hs)
            {wdata_reg, wstrb_reg} <= {s_axi_wdata, s_axi_wstrb};
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            bvalid_reg <= 1'b0;
        else if (wr_fire)
            bvalid_reg <= 1'b1;
        else if (s_axi_bready)
            bvalid_reg <= 1'b0;
        if (!aresetn)
            bresp_reg <= CMS_RESP_OKAY;
        else if (wr_fire)
            bresp_reg <= wr_resp;
    end
    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready = !w_got_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // Read side: one outstanding read, answered the cycle after it is taken.
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
    wire [7:0] stat = {step_reg, first_bad_reg, (st_reg == SQ_BG), cal_busy, data_ready_n_n_reg};
    wire ra_hit = (ra == CMS_OFS_CTRL) || (ra == CMS_OFS_OFFS) || (ra == CMS_OFS_GAIN) ||
                  (ra == CMS_OFS_DATA) || (ra == CMS_OFS_STAT);
    wire [23:0] rd_mux = (ra == CMS_OFS_CTRL) ? ctrl_reg :
                         (ra == CMS_OFS_OFFS) ? offs_reg :
                         (ra == CMS_OFS_GAIN) ? gain_reg :
                         (ra == CMS_OFS_DATA) ? dout_reg :
                         (ra == CMS_OFS_STAT) ? {16'h0000, stat} : 24'h000000;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rvalid_reg <= 1'b0;
        else if (ar_hs)
            rvalid_reg <= 1'b1;
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end
    wire [1:0] rd_resp = ra_hit ? CMS_RESP_OKAY : CMS_RESP_DECERR;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            {rdata_reg, rresp_reg} <= {32'h00000000, CMS_RESP_OKAY};
        else if (ar_hs)
            {rdata_reg, rresp_reg} <= {8'h00, rd_mux, rd_resp};
    end
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Control writes from either port; the bus wins a same-cycle collision.
    wire ctrl_wr = axi_ctrl_wr || sif.wr_ctrl;
    wire [23:0] ctrl_new = axi_ctrl_wr ? merge_strb(ctrl_reg, wdata_reg, wstrb_reg) :
                           sif.wdata;
    wire [2:0] md_new = ctrl_new[CMS_MODE_LSB +: 3];
    wire md_cal = (md_new >= CMS_MD_SELF) && (md_new <= CMS_MD_SYS_OFFS);
    // Rewriting the background code keeps the running sequence undisturbed.
    wire bg_start = (md_new == CMS_MD_BACKGND) && (st_reg != SQ_BG);
    wire start = ctrl_wr && (md_cal || bg_start);
    wire stop = ctrl_wr && !md_cal && (md_new != CMS_MD_BACKGND);
    wire bip = ctrl_reg[CMS_BIP_POS];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_reg <= CMS_CTRL_RESET;
        else if (ctrl_wr)
            ctrl_reg <= ctrl_new;
    end

    // Output period timer; a calibration command restarts it like a filter reset.
    wire tick = (per_reg == PW'(OUT_PERIOD_CYC - 1));
    always_ff @(posedge aclk)
    begin
        if (!aresetn || start)
            per_reg <= '0;
        else
            per_reg <= tick ? '0 : per_reg + PW'(1);
    end
    assign period_tick = tick;

    wire [3:0] step_n = step_reg + 4'h1;
    wire one_step = (code_reg == CMS_MD_SELF) || (code_reg == CMS_MD_SYS_OFFS);
    wire cal_t = (st_reg == SQ_CAL) && tick;
    wire bg_t = (st_reg == SQ_BG) && tick;
    wire zero_cap = cal_t && one_step && (step_n == CMS_ZERO_DONE_PERIOD);
    wire full_cap = cal_t && one_step && (step_n == CMS_FULL_DONE_PERIOD);
    wire one_done = cal_t && one_step && (step_n == CMS_ONE_STEP_PERIODS);
    wire sys_done = cal_t && !one_step && (step_n == CMS_SYS_STEP_PERIODS);
    wire sz_cap = sys_done && (code_reg == CMS_MD_SYS_ZERO);
    wire sf_cap = sys_done && (code_reg == CMS_MD_SYS_FULL);
    wire bz_cap = bg_t && (step_n == CMS_BG_ZERO_PERIOD);
    wire bf_cap = bg_t && (step_n == CMS_BG_FULL_PERIOD);
    wire bg_out = bg_t && (step_n == CMS_BG_PERIODS);
    wire nm_out = (st_reg == SQ_NORMAL) && tick;
    wire word_evt = one_done || sys_done || bg_out || nm_out;
    wire [23:0] word = conv_word - offs_reg + (bip ? CMS_MIDSCALE : 24'h000000);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || stop)
            st_reg <= SQ_NORMAL;
        else if (start)
            st_reg <= bg_start ? SQ_BG : SQ_CAL;
        else if (one_done || sys_done)
            st_reg <= SQ_NORMAL;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            code_reg <= 3'h0;
        else if (start)
            code_reg <= md_new;
        if (!aresetn || start)
            step_reg <= 4'h0;
        else if (bg_t)
            step_reg <= bg_out ? 4'h0 : step_n;
        else if (cal_t)
            step_reg <= step_n;
    end

    // Coefficients land no later than the edge that lowers data_ready_n; only system steps use that same edge.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            offs_reg <= CMS_OFFS_RESET;
        else if (zero_cap || sz_cap || bz_cap)
            offs_reg <= conv_word;
        else if (axi_offs_wr)
            offs_reg <= merge_strb(offs_reg, wdata_reg, wstrb_reg);
        else if (ser_offs_wr)
            offs_reg <= sif.wdata;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            gain_reg <= CMS_GAIN_RESET;
        else if (full_cap || sf_cap || bf_cap)
            gain_reg <= span(conv_word, offs_reg, bip);
        else if (axi_gain_wr)
            gain_reg <= merge_strb(gain_reg, wdata_reg, wstrb_reg);
        else if (ser_gain_wr)
            gain_reg <= sif.wdata;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            dout_reg <= 24'h000000;
        else if (word_evt)
            dout_reg <= word;
    end
    // A fresh word beats a read completion that lands in the same cycle.
    // A command raises the line even over an old-mode word, so it stays high until done.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || start)
            data_ready_n_n_reg <= 1'b1;
        else if (word_evt)
            data_ready_n_n_reg <= 1'b0;
        else if (sif.rd_done)
            data_ready_n_n_reg <= 1'b1;
    end
    // The flag stands over the whole first background word and drops with the second.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            {bg_pend_reg, first_bad_reg} <= 2'b00;
        else if (start)
            {bg_pend_reg, first_bad_reg} <= {bg_start, bg_start};
        else if (word_evt)
            {bg_pend_reg, first_bad_reg} <= {1'b0, bg_pend_reg && bg_out};
    end

    // Node the modulator converts during each period of the sequence.
    wire [1:0] one_node = (step_reg < CMS_ZERO_DONE_PERIOD) ?
                          ((code_reg == CMS_MD_SELF) ? CMS_NODE_SHORT : CMS_NODE_AIN) :
                          ((step_reg < CMS_FULL_DONE_PERIOD) ? CMS_NODE_REF : CMS_NODE_AIN);
    wire [1:0] bg_node = (step_reg < CMS_BG_ZERO_PERIOD) && (step_reg != 4'h0) ?
                         CMS_NODE_SHORT :
                         ((step_reg >= CMS_BG_ZERO_PERIOD) && (step_reg < CMS_BG_FULL_PERIOD) ?
                          CMS_NODE_REF : CMS_NODE_AIN);
    assign conv_node = (st_reg == SQ_BG) ? bg_node :
                       ((st_reg == SQ_CAL) && one_step ? one_node : CMS_NODE_AIN);
    assign data_ready_n = data_ready_n_n_reg;
    assign cal_busy = (st_reg == SQ_CAL);
    assign sif.ctrl = ctrl_reg;
    assign sif.offs = offs_reg;
    assign sif.gain = gain_reg;
    assign sif.dout = dout_reg;
    assign sif.dready_n = data_ready_n_n_reg;
endmodule : cms_cal_sequencer
`default_nettype wire

//--- logic/cms_pkg.sv
// Package of constants for the calibration mode sequencer.
// Notes on behaviour
// - Mode code 1,0,0 starts a one-step system offset calibration.
// - Offset: zero from the analog input, full scale from span to reference.
// - Host holds zero on the input; data_ready_n falls when the sequence ends.
// - Unipolar calibrates the endpoints; bipolar uses midscale and positive full scale.
// - Code 1,0,1 enters background calibration, interleaving shorted and reference steps.
// - Background calibration cuts the output rate to one sixth.
// - Background mode holds until a different mode code is written.
// - The first word after background enable is flagged invalid.
// - In background mode the second update after a step is settled.
// - Valid data after nine, nine or six output periods for self, offset, background.
// - Each system calibration step takes four output periods.
// - Reset loads the control register with a fixed default.
// - Serial reads reach output, control, calibration; writes never the output.
// - Serial port works as clock master or clock slave.
// - Code 0,0,1 runs self calibration: shorted inputs, then reference.
// - System calibration: 0,1,0 captures zero, then 0,1,1 captures full scale.
// - Clock-mode pin high selects master clocking, low selects external clock.
`default_nettype none
package cms_pkg;
    localparam int CMS_W = 24;
    localparam logic [7:0] CMS_OFS_CTRL = 8'h00;
    localparam logic [7:0] CMS_OFS_OFFS = 8'h04;
    localparam logic [7:0] CMS_OFS_GAIN = 8'h08;
    localparam logic [7:0] CMS_OFS_DATA = 8'h0C;
    localparam logic [7:0] CMS_OFS_STAT = 8'h10;
    localparam int CMS_MODE_LSB = 21;
    localparam int CMS_BIP_POS = 20;
    localparam int CMS_CALRD_POS = 19;
    localparam int CMS_CALSEL_POS = 18;
    localparam logic [23:0] CMS_CTRL_RESET = 24'h000000;
    localparam logic [23:0] CMS_OFFS_RESET = 24'h000000;
    localparam logic [23:0] CMS_GAIN_RESET = 24'h400000;
    localparam logic [23:0] CMS_MIDSCALE = 24'h800000;
    localparam logic [2:0] CMS_MD_SELF = 3'h1;
    localparam logic [2:0] CMS_MD_SYS_ZERO = 3'h2;
    localparam logic [2:0] CMS_MD_SYS_FULL = 3'h3;
    localparam logic [2:0] CMS_MD_SYS_OFFS = 3'h4;
    localparam logic [2:0] CMS_MD_BACKGND = 3'h5;
    localparam logic [1:0] CMS_NODE_AIN = 2'h0;
    localparam logic [1:0] CMS_NODE_SHORT = 2'h1;
    localparam logic [1:0] CMS_NODE_REF = 2'h2;
    localparam logic [3:0] CMS_ONE_STEP_PERIODS = 4'h9;
    localparam logic [3:0] CMS_ZERO_DONE_PERIOD = 4'h4;
    localparam logic [3:0] CMS_FULL_DONE_PERIOD = 4'h8;
    localparam logic [3:0] CMS_SYS_STEP_PERIODS = 4'h4;
    localparam logic [3:0] CMS_BG_PERIODS = 4'h6;
    localparam logic [3:0] CMS_BG_ZERO_PERIOD = 4'h2;
    localparam logic [3:0] CMS_BG_FULL_PERIOD = 4'h4;
    localparam logic [4:0] CMS_FRAME_BITS = 5'h18;
    localparam int CMS_CLK_NS = 10;
    localparam int CMS_OUT_PERIOD_NS = 100000;
    localparam int CMS_OUT_PERIOD_CYC = CMS_OUT_PERIOD_NS / CMS_CLK_NS;
    localparam int CMS_SCLK_HALF_NS = 80;
    localparam int CMS_SCLK_HALF_CYC = CMS_SCLK_HALF_NS / CMS_CLK_NS;
    localparam logic [1:0] CMS_RESP_OKAY = 2'h0;
    localparam logic [1:0] CMS_RESP_SLVERR = 2'h2;
    localparam logic [1:0] CMS_RESP_DECERR = 2'h3;
endpackage : cms_pkg
`default_nettype wire

//--- logic/cms_ser_if.sv
// Interface between the sequencer core and its serial port.
`default_nettype none
interface cms_ser_if;
    logic [23:0] ctrl;
    logic [23:0] offs;
    logic [23:0] gain;
    logic [23:0] dout;
    logic dready_n;
    logic wr_ctrl;
    logic wr_cal;
    logic rd_done;
    logic [23:0] wdata;
    modport core (output ctrl, offs, gain, dout, dready_n,
                  input wr_ctrl, wr_cal, rd_done, wdata);
    modport port (input ctrl, offs, gain, dout, dready_n,
                  output wr_ctrl, wr_cal, rd_done, wdata);
endinterface : cms_ser_if
`default_nettype wire

//--- logic/cms_serial_port.sv
// Serial register port of the sequencer, clock master or clock slave.
`default_nettype none
module cms_serial_port
    import cms_pkg::*;
#(
    parameter int SCLK_HALF = CMS_SCLK_HALF_CYC
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic sdata_oe,
    input wire logic rfs_n,
    input wire logic tfs_n,
    input wire logic reg_sel,
    input wire logic clk_mode,
    cms_ser_if.port sif
);
    localparam int DW = (SCLK_HALF < 2) ? 1 : $clog2(SCLK_HALF);
    if (SCLK_HALF < 1)
    begin : g_chk
        $error("SCLK_HALF must be at least one cycle.");
    end
    typedef enum logic [1:0] {SP_IDLE, SP_READ, SP_WRITE} cms_sp_t;
    cms_sp_t st_reg;
    logic [5:0] s1_reg;
    logic [5:0] s2_reg;
    logic prev_reg;
    logic sclk_reg;
    logic [DW-1:0] div_reg;
    logic [4:0] cnt_reg;
    logic [23:0] sh_reg;
    logic out_rd_reg;
    logic wr_ctrl_reg;
    logic wr_cal_reg;
    logic rd_done_reg;
    // Every pin passes two flops; the first stage feeds nothing but the second.
    always_ff @(posedge aclk)
    begin
        s1_reg <= {sclk_in, sdata_in, rfs_n, tfs_n, reg_sel, clk_mode};
        s2_reg <= s1_reg;
    end
    wire sclk_s = s2_reg[5];
    wire sdata_s = s2_reg[4];
    wire rfs_s = s2_reg[3];
    wire tfs_s = s2_reg[2];
    wire sel_s = s2_reg[1];
    wire master = s2_reg[0];
    wire calrd = sif.ctrl[CMS_CALRD_POS];
    wire calsel = sif.ctrl[CMS_CALSEL_POS];
    wire out_rd = sel_s && !calrd;
    wire [23:0] cal_word = calsel ? sif.gain : sif.offs;
    wire [23:0] rd_word = !sel_s ? sif.ctrl : (calrd ? cal_word : sif.dout);
    wire toggle = master && (st_reg != SP_IDLE) && (div_reg == DW'(SCLK_HALF - 1));
    wire rise = master ? (toggle && !sclk_reg) : (sclk_s && !prev_reg);
    wire fall = master ? (toggle && sclk_reg) : (!sclk_s && prev_reg);
    wire full = (cnt_reg == CMS_FRAME_BITS);
    wire strobe_off = (st_reg == SP_READ) ? rfs_s : tfs_s;
    wire rd_end = (st_reg == SP_READ) && full && fall;
    wire wr_end = (st_reg == SP_WRITE) && full;
    // An output read with no fresh word is refused, as the pin protocol demands.
    wire go_rd = !rfs_s && !(out_rd && sif.dready_n);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_reg <= SP_IDLE;
        else if (st_reg == SP_IDLE)
            st_reg <= go_rd ? SP_READ : (!tfs_s ? SP_WRITE : SP_IDLE);
        else if (strobe_off || rd_end || wr_end)
            st_reg <= SP_IDLE;
    end
    always_ff @(posedge aclk)
    begin
        prev_reg <= aresetn ? sclk_s : 1'b1;
        if (!aresetn || st_reg == SP_IDLE)
            div_reg <= '0;
        else
            div_reg <= toggle ? '0 : div_reg + DW'(1);
        if (!aresetn || st_reg == SP_IDLE)
            sclk_reg <= 1'b1;
        else if (toggle)
            sclk_reg <= !sclk_reg;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn || st_reg == SP_IDLE)
            cnt_reg <= 5'h00;
        else if (rise && !full)
            cnt_reg <= cnt_reg + 5'h01;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sh_reg <= 24'h000000;
        else if (st_reg == SP_IDLE)
            sh_reg <= rd_word;
        else if (st_reg == SP_WRITE && rise && !full)
            sh_reg <= {sh_reg[22:0], sdata_s};
        else if (st_reg == SP_READ && fall && cnt_reg != 5'h00 && !full)
            sh_reg <= {sh_reg[22:0], 1'b0};
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            out_rd_reg <= 1'b0;
        else if (st_reg == SP_IDLE)
            out_rd_reg <= out_rd;
        wr_ctrl_reg <= aresetn && wr_end && !sel_s;
        wr_cal_reg <= aresetn && wr_end && sel_s;
        rd_done_reg <= aresetn && rd_end && out_rd_reg;
    end
    assign sclk_out = sclk_reg;
    assign sclk_oe = master && (st_reg != SP_IDLE);
    assign sdata_out = sh_reg[23];
    assign sdata_oe = (st_reg == SP_READ);
    assign sif.wr_ctrl = wr_ctrl_reg;
    assign sif.wr_cal = wr_cal_reg;
    assign sif.rd_done = rd_done_reg;
    assign sif.wdata = sh_reg;
endmodule : cms_serial_port
`default_nettype wire

//--- verification/cms_cal_sequencer_chk.sv
// Concurrent checks on the sequencer top ports.
`default_nettype none
module cms_chk(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic data_ready_n,
    input wire logic cal_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_rd_next: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read answer late");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
    chk_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
        else $error("upper read byte set");
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    chk_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
    chk_busy_quiet: assert property (cal_busy |-> data_ready_n)
        else $error("word during calibration");
    chk_end_word: assert property ($fell(cal_busy) |-> !data_ready_n)
        else $error("calibration ended without word");
endmodule : cms_chk
bind cms_cal_sequencer cms_chk i_cms_chk (.*);
`default_nettype wire

//--- verification/cms_host_model.sv
// Host serial port model that clocks one word into the block.
`default_nettype none
module cms_host_model
    import cms_pkg::*;
(
    input wire logic go,
    input wire logic [23:0] word,
    output logic sclk,
    output logic sdata,
    output logic tfs_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        sclk = 1'b1;
        sdata = 1'b0;
        tfs_n = 1'b1;
    end
    // The clock rests high between frames; the data line shows the inverse once released.
    always @(posedge go)
    begin
        tfs_n <= 1'b0;
        for (int i = CMS_W - 1; i >= 0; i--)
        begin
            #80 sclk <= 1'b0;
            sdata <= word[i];
            #80 sclk <= 1'b1;
        end
        #160 tfs_n <= 1'b1;
        sdata <= ~sdata;
    end
endmodule : cms_host_model
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the calibration mode sequencer.
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb
    import cms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0, rfs_n = '1, reg_sel = '0, clk_mode = '0, go = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, period_tick;
    logic sclk_out, sclk_oe, sdata_out, sdata_oe, data_ready_n, cal_busy, sclk_in, sdata_in, tfs_n;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, conv_node, rs;
    logic [23:0] conv_word;
    int fail_count = 0, checked = 0, n;
    always #5 aclk = ~aclk;
    // The input levels hold still through every step.
    assign conv_word = conv_node == CMS_NODE_AIN ? 24'h000123 :
        conv_node == CMS_NODE_SHORT ? 24'h000010 : 24'h300000;
    cms_cal_sequencer #(.OUT_PERIOD_CYC(20), .SCLK_HALF(2)) i_cms_cal_sequencer (.*);
    cms_host_model i_cms_host_model (.go(go), .word(24'hE00000), .sclk(sclk_in),
        .sdata(sdata_in), .tfs_n(tfs_n));
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task automatic t_regs();
        axi_rd(CMS_OFS_CTRL);
        `CHK("ctrl reset", {8'h00, CMS_CTRL_RESET}, rd)
        axi_wr(CMS_OFS_DATA, 32'h00ABCDEF);
        `CHK("data write", CMS_RESP_SLVERR, rs)
        axi_rd(8'h20);
        `CHK("unmapped", CMS_RESP_DECERR, rs)
        $display("t_regs done");
    endtask : t_regs
    // Calibrate before trusting words.
    task automatic t_cal();
        logic [2:0] md[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
        int pr[5] = '{9, 4, 4, 9, 6};
        logic [23:0] zc[5] = '{24'h000010, 24'h000123, 24'h000123, 24'h000123, 24'h000010};
        for (int i = 0; i < 5; i++)
        begin
            axi_wr(CMS_OFS_CTRL, {8'h00, md[i], 21'h000000});
            n = 0;
            repeat (2) @(negedge aclk);
            while (data_ready_n !== 1'b0 && n < 20)
            begin
                @(negedge aclk);
                if (period_tick === 1'b1) n++;
            end
            `CHK("cal periods", pr[i], n)
            axi_rd(CMS_OFS_OFFS);
            `CHK("zero coef", {8'h00, zc[i]}, rd)
        end
        axi_rd(CMS_OFS_STAT);
        `CHK("bg stays", 2'h3, rd[3:2])
        $display("t_cal done");
    endtask : t_cal
    task automatic t_serial();
        @(posedge aclk);
        go <= 1'b1;
        wait (tfs_n === 1'b0);
        wait (tfs_n === 1'b1);
        axi_rd(CMS_OFS_CTRL);
        `CHK("serial ctrl", 32'h00E00000, rd)
        axi_rd(CMS_OFS_STAT);
        `CHK("no cal", 2'h0, {rd[2], cal_busy})
        $display("t_serial done");
    endtask : t_serial
    // The block clocks a control read out itself; sample each bit on its rising edge.
    task automatic t_master();
        logic [23:0] got;
        clk_mode <= 1'b1;
        repeat (4) @(posedge aclk);
        rfs_n <= 1'b0;
        repeat (24) @(posedge sclk_out) got = {got[22:0], sdata_out};
        `CHK("master oe", 2'h3, {sclk_oe, sdata_oe})
        @(posedge aclk);
        rfs_n <= 1'b1;
        `CHK("master read", 24'hE00000, got)
        $display("t_master done");
    endtask : t_master
    task automatic wrap_up();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    initial
    begin
        #200000;
        fail_count++;
        wrap_up();
    end
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_cal();
        t_serial();
        t_master();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
